// file: shared/pulse_count_pkg.sv
// constants and types of the pulse-count dimming link
// assumes a single 10 MHz clock; all times become cycle counts here
package pulse_count_pkg;

  // ***********************************************
  // clock and timing
  // ***********************************************
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned GLITCH_NS         = 80;
  localparam int unsigned GLITCH_CYCLES     = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TON_DELAY_TYP_NS  = 350_000;
  localparam int unsigned TON_DELAY_MAX_NS  = 450_000;
  localparam int unsigned TON_CYCLES        = TON_DELAY_TYP_NS / CLK_PERIOD_NS;
  localparam int unsigned SHDN_DELAY_NS     = 2_500_000;
  localparam int unsigned SHDN_CYCLES       = (SHDN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFTSTART_NS      = 200_000;
  localparam int unsigned RAMP_STEPS        = 8;
  localparam int unsigned RAMP_STEP_CYCLES  = SOFTSTART_NS / RAMP_STEPS / CLK_PERIOD_NS;

  // ***********************************************
  // widths
  // ***********************************************
  localparam int unsigned STEP_BITS  = 6;
  localparam int unsigned LEVEL_BITS = STEP_BITS + 1;
  localparam int unsigned RAMP_BITS  = $clog2(RAMP_STEPS + 1);
  localparam int unsigned RAMP_SHIFT = $clog2(RAMP_STEPS);
  localparam int unsigned HI_W       = $clog2(TON_CYCLES + 1);
  localparam int unsigned TMR_W      = $clog2(RAMP_STEP_CYCLES + 1);
  localparam int unsigned PROD_W     = LEVEL_BITS + RAMP_BITS;

  // ***********************************************
  // link states
  // ***********************************************
  typedef enum logic [3:0] {
    ST_SHDN  = 4'h1,
    ST_COUNT = 4'h2,
    ST_RAMP  = 4'h4,
    ST_ON    = 4'h8
  } link_state_t;

endpackage

// file: hdl/enable_filter.sv
// enable pin synchroniser, deglitch filter and rising-edge detector
// assumes en_pin is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module enable_filter #(
  parameter int unsigned FILT_CYCLES = pulse_count_pkg::GLITCH_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // pin side
  input  wire logic en_pin,
  // filtered outputs
  output logic      en_level,
  output logic      en_rise
);
  import pulse_count_pkg::*;

  localparam int unsigned FW = $clog2(FILT_CYCLES + 1);

  logic          sync1_r;
  logic          sync2_r;
  logic          clean_r;
  logic          rise_r;
  logic [FW-1:0] filt_cnt_r;

  // ***********************************************
  // two-flop synchroniser
  // ***********************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= en_pin;
      sync2_r <= sync1_r;
    end
  end

  // ***********************************************
  // deglitch: level must disagree for FILT_CYCLES+1 samples
  // ***********************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      clean_r    <= 1'b0;
      rise_r     <= 1'b0;
      filt_cnt_r <= '0;
    end else begin
      rise_r <= 1'b0;
      if (sync2_r == clean_r) begin
        filt_cnt_r <= '0;
      end else if (filt_cnt_r == FW'(FILT_CYCLES)) begin
        clean_r    <= sync2_r;
        rise_r     <= sync2_r;
        filt_cnt_r <= '0;
      end else begin
        filt_cnt_r <= filt_cnt_r + FW'(1);
      end
    end
  end

  assign en_level = clean_r;
  assign en_rise  = rise_r;

  // ***********************************************
  // checks
  // ***********************************************
  a_glitch_reject: assert property (@(posedge clock) disable iff (rst)
    (sync2_r != clean_r && filt_cnt_r == '0) |=> clean_r == $past(clean_r))
    else $error("single-sample glitch changed the enable level");

  a_rise_pulse: assert property (@(posedge clock) disable iff (rst)
    en_rise |-> en_level && !$past(clean_r))
    else $error("rise pulse without a low-to-high change");

endmodule
`default_nettype wire

// file: hdl/pulse_count_dimming.sv
// pulse-count dimming control of an LED current sink
// assumes one 10 MHz clock; the analog sink reads led_sink_current
`timescale 1ns/1ps
`default_nettype none
// Operation
// - rising edges on the enable line are counted and give a 6-bit step value selecting the sink current.
// - once the line stays high past the turn-on delay, the current ramps toward the counted setting.
// - pulses after soft-start move the current to the new setting at once, with no ramp.
// - a low level longer than the shutdown delay shuts the device down and turns the current off.
// - the current rises in equal steps of about 6.25 mA times the edge count.
// - the count runs 1 to 64, one edge being the lowest current and 64 the full current.
// - beyond 64 edges the count wraps modulo 64, the 65th edge matching the first.
// - the turn-on delay is typically 350 us and at most 450 us.
// - the shutdown delay is at least 2.5 ms of continuous low level.
// - soft-start reaches the setting in 8 increments over about 200 us.
// - glitches narrower than 80 ns are neither edges nor level changes.
module pulse_count_dimming #(
  parameter int unsigned SHDN_CYCLES = pulse_count_pkg::SHDN_CYCLES
) (
  // clock and reset
  input  wire logic                                 clock,
  input  wire logic                                 rst,
  // enable pin
  input  wire logic                                 en_pin,
  // current sink control
  output logic [pulse_count_pkg::LEVEL_BITS-1:0]    led_sink_current,
  output logic [pulse_count_pkg::STEP_BITS-1:0]     step_value,
  output logic                                      led_active
);
  import pulse_count_pkg::*;

  localparam int unsigned LO_W = $clog2(SHDN_CYCLES + 1);

  logic                  en_level;
  logic                  en_rise;
  link_state_t           st_r;
  logic [STEP_BITS-1:0]  edge_cnt_r;
  logic [STEP_BITS-1:0]  edge_cnt_nxt;
  logic [STEP_BITS-1:0]  step_value_r;
  logic [LEVEL_BITS-1:0] led_cur_r;
  logic                  led_active_r;
  logic [HI_W-1:0]       hi_cnt_r;
  logic [LO_W-1:0]       lo_cnt_r;
  logic [TMR_W-1:0]      step_tmr_r;
  logic [RAMP_BITS-1:0]  ramp_k_r;
  logic                  shdn_hit;
  logic                  ton_hit;
  logic                  ramp_tick;
  logic                  ramp_done;

  // ***********************************************
  // helpers
  // ***********************************************
  // edge count to current units of 6.25 mA; count 0 means 64 edges
  function automatic logic [LEVEL_BITS-1:0] level_of(input logic [STEP_BITS-1:0] cnt);
    level_of = (cnt == '0) ? LEVEL_BITS'(1 << STEP_BITS) : LEVEL_BITS'(cnt);
  endfunction

  // k-th of RAMP_STEPS fractions of n, rounded up
  function automatic logic [LEVEL_BITS-1:0] ramp_level(input logic [LEVEL_BITS-1:0] n,
                                                       input logic [RAMP_BITS-1:0]  k);
    logic [PROD_W-1:0] p;
    p = PROD_W'(n) * PROD_W'(k) + PROD_W'(RAMP_STEPS - 1);
    ramp_level = LEVEL_BITS'(p >> RAMP_SHIFT);
  endfunction

  // ***********************************************
  // enable input conditioning
  // ***********************************************
  enable_filter #(
    .FILT_CYCLES (GLITCH_CYCLES)
  ) u_filter (
    .clock    (clock),
    .rst      (rst),
    .en_pin   (en_pin),
    .en_level (en_level),
    .en_rise  (en_rise)
  );

  // ***********************************************
  // event terms
  // ***********************************************
  assign edge_cnt_nxt = en_rise ? edge_cnt_r + STEP_BITS'(1) : edge_cnt_r;
  assign shdn_hit  = !en_level && (st_r != ST_SHDN) && (lo_cnt_r == LO_W'(SHDN_CYCLES - 1));
  assign ton_hit   = en_level && (st_r == ST_COUNT) && (hi_cnt_r == HI_W'(TON_CYCLES - 1));
  assign ramp_tick = (st_r == ST_RAMP) && (step_tmr_r == TMR_W'(RAMP_STEP_CYCLES - 1));
  assign ramp_done = ramp_tick && (ramp_k_r == RAMP_BITS'(RAMP_STEPS));

  // ***********************************************
  // delay counters
  // ***********************************************
  always_ff @(posedge clock) begin
    if (rst || !en_level) begin
      hi_cnt_r <= '0;
    end else if (hi_cnt_r != HI_W'(TON_CYCLES)) begin
      hi_cnt_r <= hi_cnt_r + HI_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst || en_level || st_r == ST_SHDN) begin
      lo_cnt_r <= '0;
    end else if (lo_cnt_r != LO_W'(SHDN_CYCLES - 1)) begin
      lo_cnt_r <= lo_cnt_r + LO_W'(1);
    end
  end

  // ***********************************************
  // link state machine
  // ***********************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= ST_SHDN;
    end else begin
      case (st_r)
        ST_SHDN: begin
          if (en_rise) begin
            st_r <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (shdn_hit) begin
            st_r <= ST_SHDN;
          end else if (ton_hit) begin
            st_r <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (shdn_hit) begin
            st_r <= ST_SHDN;
          end else if (ramp_done) begin
            st_r <= ST_ON;
          end
        end
        ST_ON: begin
          if (shdn_hit) begin
            st_r <= ST_SHDN;
          end
        end
        default: begin
          st_r <= ST_SHDN;
        end
      endcase
    end
  end

  // ***********************************************
  // edge counter and step value
  // ***********************************************
  always_ff @(posedge clock) begin
    if (rst || shdn_hit) begin
      edge_cnt_r   <= '0;
      step_value_r <= '0;
    end else if (en_rise) begin
      edge_cnt_r   <= edge_cnt_nxt;
      step_value_r <= edge_cnt_r;
    end
  end

  // ***********************************************
  // soft-start sequencer
  // ***********************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      step_tmr_r <= '0;
      ramp_k_r   <= '0;
    end else if (ton_hit) begin
      step_tmr_r <= '0;
      ramp_k_r   <= RAMP_BITS'(1);
    end else if (ramp_tick) begin
      step_tmr_r <= '0;
      ramp_k_r   <= ramp_k_r + RAMP_BITS'(1);
    end else if (st_r == ST_RAMP) begin
      step_tmr_r <= step_tmr_r + TMR_W'(1);
    end
  end

  // ***********************************************
  // current setting
  // ***********************************************
  always_ff @(posedge clock) begin
    if (rst || shdn_hit) begin
      led_cur_r <= '0;
    end else if (ton_hit) begin
      led_cur_r <= ramp_level(level_of(edge_cnt_nxt), RAMP_BITS'(1));
    end else if (ramp_done) begin
      led_cur_r <= level_of(edge_cnt_nxt);
    end else if (ramp_tick) begin
      led_cur_r <= ramp_level(level_of(edge_cnt_nxt), ramp_k_r + RAMP_BITS'(1));
    end else if (st_r == ST_ON && en_rise) begin
      led_cur_r <= level_of(edge_cnt_nxt);
    end
  end

  always_ff @(posedge clock) begin
    if (rst || shdn_hit) begin
      led_active_r <= 1'b0;
    end else if (st_r == ST_SHDN && en_rise) begin
      led_active_r <= 1'b1;
    end
  end

  assign led_sink_current = led_cur_r;
  assign step_value       = step_value_r;
  assign led_active       = led_active_r;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_edge_count: assert property (en_rise |=> edge_cnt_r == STEP_BITS'($past(edge_cnt_r) + 1))
    else $error("edge counter did not advance by one modulo 64");

  a_step_value: assert property (en_rise |=> step_value_r == $past(edge_cnt_r))
    else $error("step value not one below the edge count");

  a_ramp_start: assert property (ton_hit |=> st_r == ST_RAMP && led_cur_r != '0 ##1 st_r == ST_RAMP)
    else $error("ramp did not start after turn-on delay");

  a_ton_delay: assert property ((st_r == ST_COUNT) ##1 (st_r == ST_RAMP) |->
    $past(hi_cnt_r) == HI_W'(TON_CYCLES - 1))
    else $error("ramp started at the wrong turn-on delay");

  a_direct_update: assert property ((st_r == ST_ON && en_rise && !shdn_hit) |=>
    led_cur_r == level_of(STEP_BITS'($past(edge_cnt_r) + 1)) && st_r == ST_ON)
    else $error("post soft-start pulse did not set current directly");

  a_shutdown: assert property (shdn_hit |=> st_r == ST_SHDN && led_cur_r == '0 && edge_cnt_r == '0 && !led_active)
    else $error("shutdown did not clear current and counter");

  a_shdn_delay: assert property ($rose(st_r == ST_SHDN) |-> $past(lo_cnt_r) == LO_W'(SHDN_CYCLES - 1))
    else $error("shutdown entered before the shutdown delay");

  a_off_in_shdn: assert property (st_r == ST_SHDN |-> led_cur_r == '0)
    else $error("current on while shut down");

  a_ramp_end: assert property (ramp_done |=> st_r == ST_ON && led_cur_r == level_of($past(edge_cnt_nxt)))
    else $error("soft-start did not end at the setting");

  a_cur_range: assert property (st_r == ST_ON |->
    led_cur_r >= LEVEL_BITS'(1) && led_cur_r <= LEVEL_BITS'(1 << STEP_BITS))
    else $error("current outside 1 to 64 steps");

  c_ramp_done: cover property (ramp_done);
  c_direct:    cover property (st_r == ST_ON && en_rise);
  c_shutdown:  cover property (shdn_hit && st_r == ST_ON);
  c_wrap:      cover property (en_rise && edge_cnt_r == '1);

endmodule
`default_nettype wire

// file: verif/host_gpio_model.sv
// host gpio model that drives the enable pin of the dimming link
// assumes the bench calls its tasks; every change lands on a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module host_gpio_model (
  // clock
  input  wire logic clock,
  // enable pin
  output var  logic en_pin
);
  // ***********************************************
  // line driver
  // ***********************************************
  initial en_pin = 1'b0;

  // n pulses of hi/lo cycles each, the line is left high afterwards
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      if (en_pin) begin
        en_pin = 1'b0;
        repeat (lo) @(negedge clock);
      end
      en_pin = 1'b1;
      repeat (hi) @(negedge clock);
    end
  endtask

  // line low for as long as the led is to stay off
  task automatic release_line();
    en_pin = 1'b0;
  endtask

  // one-cycle excursion to level v, then back
  task automatic glitch(input logic v);
    en_pin = v;
    @(negedge clock);
    en_pin = ~v;
  endtask
endmodule
`default_nettype wire

// file: verif/test_pulse_count_dimming.sv
// testbench of the pulse-count dimming block
// assumes a 10 MHz clock and a shortened shutdown delay of 50 cycles
`timescale 1ns/1ps
`default_nettype none
module test_pulse_count_dimming;
  import pulse_count_pkg::*;
  // ***********************************************
  // signals and instances
  // ***********************************************
  logic                  clock;
  logic                  rst;
  wire logic             en_pin;
  logic [LEVEL_BITS-1:0] led_sink_current;
  logic [STEP_BITS-1:0]  step_value;
  logic                  led_active;
  int                    err_count = 0;
  int                    n_compared = 0;
  int                    cycles = 0;

  host_gpio_model i_host_gpio_model (.clock(clock), .en_pin(en_pin));
  pulse_count_dimming #(.SHDN_CYCLES(50)) i_pulse_count_dimming (
    .clock            (clock),
    .rst              (rst),
    .en_pin           (en_pin),
    .led_sink_current (led_sink_current),
    .step_value       (step_value),
    .led_active       (led_active)
  );

  initial clock = 1'b0;
  always #50 clock = ~clock;

  // ***********************************************
  // helpers
  // ***********************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, the whole run needs under 8000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_reset();
    check("reset current", led_sink_current, 0);
    check("reset step", step_value, 0);
    check("reset active", led_active, 0);
    $display("test reset done");
  endtask

  // 64 edges, hold high, soft-start to full current
  task automatic t_full();
    int t;
    int chg;
    logic [LEVEL_BITS-1:0] prev;
    i_host_gpio_model.pulses(64, 10, 10);
    cyc(3300);
    check("current before turn-on", led_sink_current, 0);
    t = 0;
    while (led_sink_current === 7'h00 && t < 1190) begin
      cyc(1);
      t++;
    end
    check("first ramp level", led_sink_current, 8);
    prev = led_sink_current;
    chg = 1;
    t = 0;
    while (led_sink_current !== 7'h40 && t < 2500) begin
      cyc(1);
      t++;
      if (led_sink_current !== prev) chg++;
      prev = led_sink_current;
    end
    check("ramp increments", chg, 8);
    check("ramp time", t >= 1500 && t <= 2250, 1);
    check("full current", led_sink_current, 64);
    check("full step", step_value, 63);
    check("active", led_active, 1);
    $display("test full ramp done");
  endtask

  // three more edges after soft-start: 67 wraps to 3, set at once
  task automatic t_direct();
    // full level comes one interval before soft-start ends
    cyc(260);
    check("on after soft-start", led_sink_current, 64);
    i_host_gpio_model.pulses(3, 10, 10);
    cyc(5);
    check("direct current", led_sink_current, 3);
    check("wrapped step", step_value, 2);
    i_host_gpio_model.glitch(1'b0);
    cyc(20);
    check("low glitch current", led_sink_current, 3);
    check("low glitch step", step_value, 2);
    $display("test direct update done");
  endtask

  // long low shuts down, counter restarts from the lowest step
  task automatic shutdown_delay();
    int t;
    i_host_gpio_model.release_line();
    cyc(40);
    check("current before shutdown", led_sink_current, 3);
    t = 40;
    while (led_active === 1'b1 && t < 200) begin
      cyc(1);
      t++;
    end
    check("shutdown delay held", t >= 50 && t < 200, 1);
    check("current off", led_sink_current, 0);
    check("step cleared", step_value, 0);
    i_host_gpio_model.glitch(1'b1);
    cyc(20);
    check("high glitch ignored", led_active, 0);
    i_host_gpio_model.pulses(1, 10, 10);
    cyc(5);
    check("restart step", step_value, 0);
    check("restart active", led_active, 1);
    $display("test shutdown done");
  endtask

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    cyc(2);
    t_reset();
    t_full();
    t_direct();
    shutdown_delay();
    end_of_test();
  end
endmodule
`default_nettype wire
